// [src/spp_regs.vh]
// Constants for the sequential port pointer block
`ifndef SPP_REGS_VH
`define SPP_REGS_VH

// Widths
`define SPP_DATA_W        16
`define SPP_PTR_W         12
`define SPP_REG_ADDR_W    3
`define SPP_REG_DATA_W    13

// Command register offsets
`define SPP_OFS_START_ONE 3'h0
`define SPP_OFS_END_ONE   3'h1
`define SPP_OFS_START_TWO 3'h2
`define SPP_OFS_END_TWO   3'h3
`define SPP_OFS_FLAGS     3'h4
`define SPP_OFS_CTRL      3'h5

// Control register fields
`define SPP_CTRL_FLAG_ONE_BIT 0
`define SPP_CTRL_FLAG_TWO_BIT 1

// Reset values
`define SPP_PTR_RST       12'h000
`define SPP_START_RST     12'h000
`define SPP_END_RST       12'hfff
`define SPP_CTRL_RST      13'h0000

// Timing: cycles from pointer-load sample to pointer change
`define SPP_LOAD_DELAY    1

`endif

// [src/spp_word_store.v]
// Word storage of the sequential port, one write and one registered read
`timescale 1ns/1ps
`default_nettype none
`include "spp_regs.vh"

module spp_word_store (
  // Clock
  input  wire                      clk_in,
  // Write side
  input  wire                      wr_en_in,
  input  wire [`SPP_PTR_W-1:0]     wr_addr_in,
  input  wire [`SPP_DATA_W-1:0]    wr_data_in,
  // Read side
  input  wire [`SPP_PTR_W-1:0]     rd_addr_in,
  output reg  [`SPP_DATA_W-1:0]    rd_data_out
);

  reg [`SPP_DATA_W-1:0] mem_q [0:(1<<`SPP_PTR_W)-1];

  always @(posedge clk_in) begin
    if (wr_en_in) begin
      mem_q[wr_addr_in] <= wr_data_in;
    end
    rd_data_out <= mem_q[rd_addr_in];
  end

endmodule // spp_word_store
`default_nettype wire

// [src/spp_pair_buf.v]
// Two-entry buffer with valid and ready on both sides
`timescale 1ns/1ps
`default_nettype none
`include "spp_regs.vh"

module spp_pair_buf (
  // Clock and reset
  input  wire                      clk_in,
  input  wire                      srst_in,
  // Filling side
  input  wire                      in_valid_in,
  input  wire [`SPP_DATA_W-1:0]    in_data_in,
  output wire                      in_ready_out,
  // Draining side
  output reg                       out_valid_out,
  output reg  [`SPP_DATA_W-1:0]    out_data_out,
  input  wire                      out_ready_in
);

  reg                   skid_valid_q;
  reg [`SPP_DATA_W-1:0] skid_data_q;
  wire                  in_fire;

  assign in_ready_out = ~skid_valid_q;
  assign in_fire      = in_valid_in & ~skid_valid_q;

  always @(posedge clk_in) begin
    if (srst_in) begin
      out_valid_out <= 1'b0;
      out_data_out  <= 16'h0000;
      skid_valid_q  <= 1'b0;
      skid_data_q   <= 16'h0000;
    end else if (~out_valid_out | out_ready_in) begin
      // Output slot free or draining
      if (skid_valid_q) begin
        out_valid_out <= 1'b1;
        out_data_out  <= skid_data_q;
        skid_valid_q  <= 1'b0;
      end else begin
        out_valid_out <= in_fire;
        if (in_fire) begin
          out_data_out <= in_data_in;
        end
      end
    end else if (in_fire) begin
      // Output stalled: park word in second entry
      skid_valid_q <= 1'b1;
      skid_data_q  <= in_data_in;
    end
  end

endmodule // spp_pair_buf
`default_nettype wire

// [src/spp_seq_port.v]
// Sequential access port: pointer, load, read/write cycles, end flags
`timescale 1ns/1ps
`default_nettype none
`include "spp_regs.vh"

module spp_seq_port (
  // Clock and reset
  input  wire                         clk_in,
  input  wire                         srst_in,
  // Sequential data bus
  input  wire [`SPP_DATA_W-1:0]       seq_data_bus_in,
  output wire [`SPP_DATA_W-1:0]       seq_data_bus_out,
  output reg                          seq_data_bus_oe_out,
  output wire                         seq_data_valid_out,
  input  wire                         seq_data_ready_in,
  // Sequential controls
  input  wire                         seq_port_enable_n_in,
  input  wire                         pointer_advance_n_in,
  input  wire                         seq_read_write_sel_in,
  input  wire                         pointer_load_n_in,
  input  wire                         start_one_load_n_in,
  input  wire                         start_two_load_n_in,
  input  wire                         seq_output_enable_n_in,
  // End flags and pointer
  output reg                          buffer_one_end_flag_n_out,
  output reg                          buffer_two_end_flag_n_out,
  output reg  [`SPP_PTR_W-1:0]        pointer_out,
  // Command register access
  input  wire                         reg_select_n_in,
  input  wire                         rand_enable_n_in,
  input  wire [`SPP_REG_ADDR_W-1:0]   reg_addr_in,
  input  wire                         reg_read_write_in,
  input  wire [`SPP_REG_DATA_W-1:0]   reg_wdata_in,
  output reg  [`SPP_REG_DATA_W-1:0]   reg_rdata_out
);

  // Register decode
  function reg_hit;
    input [`SPP_REG_ADDR_W-1:0] addr;
    input [`SPP_REG_ADDR_W-1:0] ofs;
    begin
      reg_hit = (addr == ofs);
    end
  endfunction

  // End match on an increment only, never on a load
  function end_hit;
    input                  inc;
    input [`SPP_PTR_W-1:0] nxt;
    input [`SPP_PTR_W-1:0] lim;
    begin
      end_hit = inc & (nxt == lim);
    end
  endfunction

  // Synchronised output enable
  reg                      soe_meta_q;
  reg                      soe_sync_n_q;

  // Port state
  reg                      port_on_q;
  reg                      load_pend_q;
  reg [`SPP_PTR_W-1:0]     load_hold_q;
  reg [`SPP_PTR_W-1:0]     ptr_d;
  reg                      ptr_inc;
  reg [`SPP_PTR_W-1:0]     start_one_q;
  reg [`SPP_PTR_W-1:0]     start_two_q;
  reg [`SPP_PTR_W-1:0]     end_one_q;
  reg [`SPP_PTR_W-1:0]     end_two_q;
  reg [`SPP_REG_DATA_W-1:0] ctrl_q;
  // Read issued last edge, its word lands in the buffer next edge
  reg                      rd_pend_q;

  // Cycle decode
  wire                     reg_access;
  wire                     reg_wr;
  wire                     wr_cycle;
  wire                     rd_req;
  wire                     rd_ok;
  wire                     rd_cycle;
  wire [`SPP_PTR_W-1:0]    ptr_plus;
  wire                     hit_one;
  wire                     hit_two;
  wire                     clr_one;
  wire                     clr_two;
  wire                     wr_go;

  // End flag vectors, index 0 for flag one
  genvar                   gi;
  wire [1:0]               flag_n_now;
  wire [1:0]               flag_hit;
  wire [1:0]               flag_clr;
  wire [1:0]               flag_n_d;

  // Storage and buffer links
  wire [`SPP_DATA_W-1:0]   mem_rdata;
  wire                     buf_in_ready;
  wire                     buf_out_valid;
  wire [`SPP_DATA_W-1:0]   buf_out_data;

  assign reg_access = ~reg_select_n_in & rand_enable_n_in;
  assign reg_wr     = reg_access & ~reg_read_write_in;

  assign wr_cycle   = ~seq_port_enable_n_in & ~seq_read_write_sel_in;
  // No store while reset is held
  assign wr_go      = wr_cycle & ~srst_in;
  assign rd_req     = ~seq_port_enable_n_in & seq_read_write_sel_in & ~soe_sync_n_q;
  // Hold reads back while a word in flight could overrun the buffer
  assign rd_ok      = buf_in_ready & ~(rd_pend_q & buf_out_valid);
  assign rd_cycle   = rd_req & rd_ok;

  assign ptr_plus   = pointer_out + 12'h001;
  assign hit_one    = end_hit(ptr_inc, ptr_d, end_one_q);
  assign hit_two    = end_hit(ptr_inc, ptr_d, end_two_q);
  assign clr_one    = reg_wr & reg_hit(reg_addr_in, `SPP_OFS_CTRL) &
                      ~reg_wdata_in[`SPP_CTRL_FLAG_ONE_BIT];
  assign clr_two    = reg_wr & reg_hit(reg_addr_in, `SPP_OFS_CTRL) &
                      ~reg_wdata_in[`SPP_CTRL_FLAG_TWO_BIT];

  assign flag_n_now = {buffer_two_end_flag_n_out, buffer_one_end_flag_n_out};
  assign flag_hit   = {hit_two, hit_one};
  assign flag_clr   = {clr_two, clr_one};

  // Output enable crosses in from an unclocked pin
  always @(posedge clk_in) begin
    if (srst_in) begin
      soe_meta_q   <= 1'b1;
      soe_sync_n_q <= 1'b1;
    end else begin
      soe_meta_q   <= seq_output_enable_n_in;
      soe_sync_n_q <= soe_meta_q;
    end
  end

  // Pointer next value
  // A pending load outranks both start loads and the advance
  always @* begin
    ptr_d   = pointer_out;
    ptr_inc = 1'b0;
    if (load_pend_q) begin
      ptr_d = load_hold_q;
    end else if (~start_one_load_n_in) begin
      ptr_d = start_one_q;
    end else if (~start_two_load_n_in) begin
      ptr_d = start_two_q;
    end else if (~pointer_advance_n_in) begin
      ptr_d   = ptr_plus;
      ptr_inc = 1'b1;
    end
  end

  // Pointer, load holding and port state
  always @(posedge clk_in) begin
    if (srst_in) begin
      pointer_out <= `SPP_PTR_RST;
      load_hold_q <= `SPP_PTR_RST;
      load_pend_q <= 1'b0;
      port_on_q   <= 1'b0;
      rd_pend_q   <= 1'b0;
    end else begin
      pointer_out <= ptr_d;
      port_on_q   <= ~seq_port_enable_n_in;
      load_pend_q <= ~pointer_load_n_in;
      rd_pend_q   <= rd_cycle;
      if (~pointer_load_n_in) begin
        load_hold_q <= seq_data_bus_in[`SPP_PTR_W-1:0];
      end
    end
  end

  // End flags, a hit wins over a clear in the same cycle
  generate
    for (gi = 0; gi < 2; gi = gi + 1) begin : g_flag
      assign flag_n_d[gi] = flag_hit[gi] ? 1'b0 :
                            (flag_clr[gi] ? 1'b1 : flag_n_now[gi]);
    end
  endgenerate

  always @(posedge clk_in) begin
    if (srst_in) begin
      buffer_one_end_flag_n_out <= 1'b1;
      buffer_two_end_flag_n_out <= 1'b1;
    end else begin
      buffer_one_end_flag_n_out <= flag_n_d[0];
      buffer_two_end_flag_n_out <= flag_n_d[1];
    end
  end

  // Command register writes
  always @(posedge clk_in) begin
    if (srst_in) begin
      start_one_q <= `SPP_START_RST;
      start_two_q <= `SPP_START_RST;
      end_one_q   <= `SPP_END_RST;
      end_two_q   <= `SPP_END_RST;
      ctrl_q      <= `SPP_CTRL_RST;
    end else if (reg_wr) begin
      case (reg_addr_in)
        `SPP_OFS_START_ONE: begin
          start_one_q <= reg_wdata_in[`SPP_PTR_W-1:0];
        end
        `SPP_OFS_END_ONE: begin
          end_one_q <= reg_wdata_in[`SPP_PTR_W-1:0];
        end
        `SPP_OFS_START_TWO: begin
          start_two_q <= reg_wdata_in[`SPP_PTR_W-1:0];
        end
        `SPP_OFS_END_TWO: begin
          end_two_q <= reg_wdata_in[`SPP_PTR_W-1:0];
        end
        `SPP_OFS_CTRL: begin
          ctrl_q <= reg_wdata_in;
        end
        default: begin
          ctrl_q <= ctrl_q;
        end
      endcase
    end
  end

  // Command register reads
  always @(posedge clk_in) begin
    if (srst_in) begin
      reg_rdata_out <= 13'h0000;
    end else if (reg_access & reg_read_write_in) begin
      case (reg_addr_in)
        `SPP_OFS_START_ONE: begin
          reg_rdata_out <= {1'b0, start_one_q};
        end
        `SPP_OFS_END_ONE: begin
          reg_rdata_out <= {1'b0, end_one_q};
        end
        `SPP_OFS_START_TWO: begin
          reg_rdata_out <= {1'b0, start_two_q};
        end
        `SPP_OFS_END_TWO: begin
          reg_rdata_out <= {1'b0, end_two_q};
        end
        `SPP_OFS_FLAGS: begin
          reg_rdata_out <= {11'h000, ~buffer_two_end_flag_n_out,
                            ~buffer_one_end_flag_n_out};
        end
        `SPP_OFS_CTRL: begin
          reg_rdata_out <= {ctrl_q[`SPP_REG_DATA_W-1:2], ~buffer_two_end_flag_n_out,
                            ~buffer_one_end_flag_n_out};
        end
        default: begin
          reg_rdata_out <= 13'h0000;
        end
      endcase
    end
  end

  spp_word_store u_store (
    .clk_in      (clk_in),
    .wr_en_in    (wr_go),
    .wr_addr_in  (pointer_out),
    .wr_data_in  (seq_data_bus_in),
    .rd_addr_in  (pointer_out),
    .rd_data_out (mem_rdata)
  );

  spp_pair_buf u_buf (
    .clk_in        (clk_in),
    .srst_in       (srst_in),
    .in_valid_in   (rd_pend_q),
    .in_data_in    (mem_rdata),
    .in_ready_out  (buf_in_ready),
    .out_valid_out (buf_out_valid),
    .out_data_out  (buf_out_data),
    .out_ready_in  (seq_data_ready_in)
  );

  // Word and valid come straight from the buffer's output flops, so a
  // ready from the receiver always acknowledges the word it is shown
  assign seq_data_bus_out   = buf_out_data;
  assign seq_data_valid_out = buf_out_valid;

  // Data bus drive
  always @(posedge clk_in) begin
    if (srst_in) begin
      seq_data_bus_oe_out <= 1'b0;
    end else begin
      seq_data_bus_oe_out <= port_on_q & ~soe_sync_n_q;
    end
  end

endmodule // spp_seq_port
`default_nettype wire

// [dv/spp_sink.sv]
// Receiving side model: takes read words prompt, slow or stopped
`timescale 1ns/1ps
`default_nettype none
module spp_sink (
  // Clock and reset
  input  wire logic        clk_in,
  input  wire logic        srst_in,
  // Word stream
  input  wire logic        valid_in,
  input  wire logic [15:0] data_in,
  output logic             ready_out,
  // Pace and record
  input  wire logic [1:0]  mode_in,
  output logic [7:0]       n_out,
  output logic [15:0]      last_out
);
  logic ph_q;
  // Mode 0 prompt, 1 every other cycle, 2 stopped
  assign ready_out = (mode_in == 2'h0) || (mode_in == 2'h1 && ph_q);
  always @(posedge clk_in) begin
    if (srst_in) begin
      ph_q <= 1'b0;
      n_out <= 8'h00;
      last_out <= 16'h0000;
    end else begin
      ph_q <= ~ph_q;
      if (valid_in && ready_out) begin
        n_out <= n_out + 8'h01;
        last_out <= data_in;
      end
    end
  end
endmodule // spp_sink
`default_nettype wire

// [dv/spp_seq_port_assertions.sv]
// Checker for the sequential port pointer block
`timescale 1ns/1ps
`default_nettype none
module spp_seq_port_chk (
  // Clock and reset
  input wire logic        clk_in,
  input wire logic        srst_in,
  // Sequential side
  input wire logic [15:0] seq_data_bus_in,
  input wire logic [15:0] seq_data_bus_out,
  input wire logic        seq_data_bus_oe_out,
  input wire logic        seq_data_valid_out,
  input wire logic        seq_data_ready_in,
  input wire logic        pointer_advance_n_in,
  input wire logic        pointer_load_n_in,
  input wire logic        start_one_load_n_in,
  input wire logic        start_two_load_n_in,
  input wire logic        seq_output_enable_n_in,
  input wire logic        buffer_one_end_flag_n_out,
  input wire logic        buffer_two_end_flag_n_out,
  input wire logic [11:0] pointer_out,
  // Command registers
  input wire logic        reg_select_n_in,
  input wire logic        rand_enable_n_in,
  input wire logic [2:0]  reg_addr_in,
  input wire logic        reg_read_write_in,
  input wire logic [12:0] reg_wdata_in
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (srst_in);
  logic [11:0] sh_q [0:3];
  wire reg_wr_w = !reg_select_n_in && rand_enable_n_in && !reg_read_write_in;
  wire calm_w = start_one_load_n_in && start_two_load_n_in && pointer_load_n_in;
  // Shadow of start and end addresses
  always @(posedge clk_in) begin
    if (srst_in) begin
      sh_q[0] <= 12'h000;
      sh_q[1] <= 12'hfff;
      sh_q[2] <= 12'h000;
      sh_q[3] <= 12'hfff;
    end else if (reg_wr_w && !reg_addr_in[2]) begin
      sh_q[reg_addr_in[1:0]] <= reg_wdata_in[11:0];
    end
  end
  property p_adv;
    calm_w && $past(pointer_load_n_in) && !pointer_advance_n_in
      |=> pointer_out == $past(pointer_out) + 12'h001;
  endproperty
  a_adv: assert property (p_adv) else $error("pointer did not step");
  property p_idle;
    calm_w && $past(pointer_load_n_in) && pointer_advance_n_in |=> $stable(pointer_out);
  endproperty
  a_idle: assert property (p_idle) else $error("pointer moved");
  property p_load;
    !pointer_load_n_in |=> ##1 pointer_out == $past(seq_data_bus_in[11:0], 2);
  endproperty
  a_load: assert property (p_load) else $error("load value wrong");
  property p_st1;
    !start_one_load_n_in && pointer_load_n_in && $past(pointer_load_n_in)
      |=> pointer_out == $past(sh_q[0]);
  endproperty
  a_st1: assert property (p_st1) else $error("start one wrong");
  property p_f1;
    $fell(buffer_one_end_flag_n_out)
      |-> pointer_out == sh_q[1] && pointer_out == $past(pointer_out) + 12'h001;
  endproperty
  a_f1: assert property (p_f1) else $error("flag one no hit");
  property p_clr;
    reg_wr_w && reg_addr_in == 3'h5 && !reg_wdata_in[0] && pointer_advance_n_in
      |=> buffer_one_end_flag_n_out;
  endproperty
  a_clr: assert property (p_clr) else $error("flag one not cleared");
  property p_rst;
    disable iff (1'b0) srst_in |=> pointer_out == 12'h000 && !seq_data_valid_out
      && buffer_one_end_flag_n_out && buffer_two_end_flag_n_out;
  endproperty
  a_rst: assert property (p_rst) else $error("reset state wrong");
  property p_oe;
    seq_output_enable_n_in [*3] |=> ##2 !seq_data_bus_oe_out;
  endproperty
  a_oe: assert property (p_oe) else $error("bus driven");
  property p_hold;
    seq_data_valid_out && !seq_data_ready_in
      |=> seq_data_valid_out && $stable(seq_data_bus_out);
  endproperty
  a_hold: assert property (p_hold) else $error("word lost");
endmodule // spp_seq_port_chk
bind spp_seq_port spp_seq_port_chk spp_seq_port_chk_i (
  .clk_in(clk_in), .srst_in(srst_in), .seq_data_bus_in(seq_data_bus_in),
  .seq_data_bus_out(seq_data_bus_out), .seq_data_bus_oe_out(seq_data_bus_oe_out),
  .seq_data_valid_out(seq_data_valid_out), .seq_data_ready_in(seq_data_ready_in),
  .pointer_advance_n_in(pointer_advance_n_in), .pointer_load_n_in(pointer_load_n_in),
  .start_one_load_n_in(start_one_load_n_in), .start_two_load_n_in(start_two_load_n_in),
  .seq_output_enable_n_in(seq_output_enable_n_in),
  .buffer_one_end_flag_n_out(buffer_one_end_flag_n_out),
  .buffer_two_end_flag_n_out(buffer_two_end_flag_n_out), .pointer_out(pointer_out),
  .reg_select_n_in(reg_select_n_in), .rand_enable_n_in(rand_enable_n_in),
  .reg_addr_in(reg_addr_in), .reg_read_write_in(reg_read_write_in),
  .reg_wdata_in(reg_wdata_in));
`default_nettype wire

// [dv/spp_seq_port_tb.sv]
// Self-checking bench for the sequential port pointer block
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin fails++; \
  $display("unexpected t=%0t got=%h exp=%h", $time, g, e); end end
module spp_seq_port_tb;
  logic clk_in = 1'b0;
  logic srst_in = 1'b1;
  logic [15:0] seq_data_bus_in = 16'h0000;
  logic seq_port_enable_n_in = 1'b1, pointer_advance_n_in = 1'b1;
  logic seq_read_write_sel_in = 1'b1, pointer_load_n_in = 1'b1;
  logic start_one_load_n_in = 1'b1, start_two_load_n_in = 1'b1;
  logic seq_output_enable_n_in = 1'b0, reg_select_n_in = 1'b1;
  logic rand_enable_n_in = 1'b1, reg_read_write_in = 1'b1;
  logic [1:0] mode = 2'h1;
  logic [2:0] reg_addr_in = 3'h0;
  logic [12:0] reg_wdata_in = 13'h0000;
  wire logic [15:0] seq_data_bus_out, got;
  wire logic seq_data_bus_oe_out, seq_data_valid_out, seq_data_ready_in;
  wire logic buffer_one_end_flag_n_out, buffer_two_end_flag_n_out;
  wire logic [11:0] pointer_out;
  wire logic [12:0] reg_rdata_out;
  wire logic [7:0] n_got;
  int fails = 0, n_checks = 0, cyc = 0;
  always #2 clk_in = ~clk_in;
  spp_seq_port spp_seq_port_i (
    .clk_in(clk_in), .srst_in(srst_in), .seq_data_bus_in(seq_data_bus_in),
    .seq_data_bus_out(seq_data_bus_out), .seq_data_bus_oe_out(seq_data_bus_oe_out),
    .seq_data_valid_out(seq_data_valid_out), .seq_data_ready_in(seq_data_ready_in),
    .seq_port_enable_n_in(seq_port_enable_n_in), .pointer_advance_n_in(pointer_advance_n_in),
    .seq_read_write_sel_in(seq_read_write_sel_in), .pointer_load_n_in(pointer_load_n_in),
    .start_one_load_n_in(start_one_load_n_in), .start_two_load_n_in(start_two_load_n_in),
    .seq_output_enable_n_in(seq_output_enable_n_in),
    .buffer_one_end_flag_n_out(buffer_one_end_flag_n_out),
    .buffer_two_end_flag_n_out(buffer_two_end_flag_n_out), .pointer_out(pointer_out),
    .reg_select_n_in(reg_select_n_in), .rand_enable_n_in(rand_enable_n_in),
    .reg_addr_in(reg_addr_in), .reg_read_write_in(reg_read_write_in),
    .reg_wdata_in(reg_wdata_in), .reg_rdata_out(reg_rdata_out));
  spp_sink spp_sink_i (.clk_in(clk_in), .srst_in(srst_in), .valid_in(seq_data_valid_out),
    .data_in(seq_data_bus_out), .ready_out(seq_data_ready_in), .mode_in(mode),
    .n_out(n_got), .last_out(got));
  task automatic ed(input int n);
    repeat (n) @(posedge clk_in);
  endtask
  task automatic ld(input logic [11:0] a);
    ed(1);
    pointer_load_n_in <= 1'b0;
    seq_data_bus_in <= {4'h0, a};
    ed(1);
    pointer_load_n_in <= 1'b1;
    ed(1);
    @(negedge clk_in);
    `CHK(pointer_out, a)
  endtask
  task automatic seq(input logic ce_n, input logic rw, input logic adv_n);
    ed(1);
    seq_port_enable_n_in <= ce_n;
    seq_read_write_sel_in <= rw;
    pointer_advance_n_in <= adv_n;
  endtask
  task automatic rd(input logic [11:0] a, input logic [15:0] e);
    logic [7:0] n0;
    n0 = n_got;
    ld(a);
    seq(1'b0, 1'b1, 1'b1);
    seq(1'b1, 1'b1, 1'b1);
    for (int k = 0; k < 30 && n_got == n0; k++) ed(1);
    @(negedge clk_in);
    `CHK(n_got, n0 + 8'h01)
    `CHK(got, e)
  endtask
  task automatic rg(input logic [2:0] a, input logic rw, input logic [12:0] d);
    ed(1);
    reg_select_n_in <= 1'b0;
    reg_addr_in <= a;
    reg_read_write_in <= rw;
    reg_wdata_in <= d;
    ed(1);
    reg_select_n_in <= 1'b1;
    reg_read_write_in <= 1'b1;
    @(negedge clk_in);
  endtask
  task automatic t_reset;
    `CHK({pointer_out, buffer_one_end_flag_n_out, seq_data_valid_out}, 14'h0002)
    rg(3'h1, 1'b1, 13'h0000);
    `CHK(reg_rdata_out, 13'h0fff)
    rg(3'h7, 1'b1, 13'h0000);
    `CHK(reg_rdata_out, 13'h0000)
    $display("t_reset done");
  endtask
  task automatic t_burst;
    ld(12'hfff);
    seq(1'b0, 1'b0, 1'b0);
    seq_data_bus_in <= 16'h1111;
    ed(1);
    seq_data_bus_in <= 16'h2222;
    seq(1'b1, 1'b1, 1'b1);
    @(negedge clk_in);
    `CHK(pointer_out, 12'h001)
    rd(12'hfff, 16'h1111);
    rd(12'h000, 16'h2222);
    $display("t_burst done");
  endtask
  task automatic t_start(input int k);
    logic [11:0] s;
    s = k ? 12'h200 : 12'h100;
    rg(3'(2 * k), 1'b0, {1'b0, s});
    rg(3'(2 * k + 1), 1'b0, {1'b0, s + 12'h002});
    ed(1);
    if (k) start_two_load_n_in <= 1'b0;
    else start_one_load_n_in <= 1'b0;
    ed(1);
    {start_one_load_n_in, start_two_load_n_in} <= 2'h3;
    @(negedge clk_in);
    `CHK(pointer_out, s)
    seq(1'b1, 1'b1, 1'b0);
    seq(1'b1, 1'b1, 1'b0);
    seq(1'b1, 1'b1, 1'b1);
    @(negedge clk_in);
    `CHK({buffer_one_end_flag_n_out, buffer_two_end_flag_n_out}, k ? 2'h2 : 2'h1)
    rg(3'h5, 1'b0, 13'h0000);
    `CHK({buffer_one_end_flag_n_out, buffer_two_end_flag_n_out}, 2'h3)
    $display("t_start done");
  endtask
  task automatic t_oe;
    logic [7:0] n0;
    mode <= 2'h2;
    ld(12'h000);
    n0 = n_got;
    seq(1'b0, 1'b1, 1'b1);
    ed(8);
    @(negedge clk_in);
    `CHK({seq_data_bus_oe_out, seq_data_valid_out}, 2'h3)
    ed(1);
    seq_output_enable_n_in <= 1'b1;
    ed(5);
    @(negedge clk_in);
    `CHK(seq_data_bus_oe_out, 1'b0)
    seq(1'b1, 1'b1, 1'b1);
    seq_output_enable_n_in <= 1'b0;
    mode <= 2'h0;
    ed(6);
    @(negedge clk_in);
    `CHK({seq_data_bus_oe_out, seq_data_valid_out}, 2'h0)
    `CHK(n_got, n0 + 8'h02)
    `CHK(got, 16'h2222)
    $display("t_oe done");
  endtask
  task automatic finish_test;
    $display("checks %0d fails %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  always @(posedge clk_in) begin
    cyc++;
    if (cyc == 4000) begin
      fails++;
      finish_test();
    end
  end
  initial begin
    ed(8);
    srst_in <= 1'b0;
    ed(1);
    @(negedge clk_in);
    t_reset();
    t_burst();
    t_start(0);
    t_start(1);
    t_oe();
    finish_test();
  end
endmodule // spp_seq_port_tb
`default_nettype wire
